/* verilog/wwd_pkg.sv */
/*
  Constants, register map and state types of the windowed supervisor.
  Assumes a single clock domain; the counter clock arrives as a synchronous level input.
*/
// Summary of operation
// - Counter clock divided by four; each prescaled tick decrements a 24-bit counter.
// - Timeout constants below 0xff are loaded as 0xff.
// - Writing 0xaa then 0x55 to the key register reloads the counter.
// - Counting starts only at the first key sequence after run enable is set.
// - Reaching zero without a reload raises a timeout event.
// - A reload while the counter is above the early limit is a timeout event.
// - With reset on timeout set, an expiry requests a chip reset.
// - Timeout flag survives the self-caused reset; software clears it.
// - Warning flag sets when the counter equals the alert compare value.
// - While enabled, a wrong key sequence is an immediate timeout event.
// - Once enabled, only a hardware or self-caused reset stops the timer.
// - With reload protect, constant writes accepted only below alert and early limits.
// - Clock lock keeps the counting clock source from being disabled.
// - Setup and constant writes take effect three counter-clock cycles later.
// - Counter is captured on the counter clock, then moved to the bus view.
// - Early limit resets to 0xffffff; constant and counter reset to 0xff.
// - Run enable and reset on timeout ignore writes of zero once set.
// - Timeout flag sets on expiry, key error, early reload or protected write; zero clears it.
// - Warning flag sets at the compare value; writing one clears it.
`default_nettype none
package wwd_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFS_SETUP = 12'h000;
  localparam logic [11:0] OFS_TC    = 12'h004;
  localparam logic [11:0] OFS_KEY   = 12'h008;
  localparam logic [11:0] OFS_VIEW  = 12'h00c;
  localparam logic [11:0] OFS_ALERT = 12'h014;
  localparam logic [11:0] OFS_EARLY = 12'h018;
  localparam int BIT_RUN  = 0;
  localparam int BIT_RST  = 1;
  localparam int BIT_TOF  = 2;
  localparam int BIT_WRN  = 3;
  localparam int BIT_PROT = 4;
  localparam int BIT_LOCK = 5;
  // ----------------------------------------
  // Values and timing
  // ----------------------------------------
  localparam logic [23:0] TC_RST    = 24'h0000ff;
  localparam logic [23:0] TC_MIN    = 24'h0000ff;
  localparam logic [23:0] CNT_RST   = 24'h0000ff;
  localparam logic [23:0] EARLY_RST = 24'hffffff;
  localparam logic [31:0] ALERT_RST = 32'h00000000;
  localparam logic [7:0]  KEY_FIRST  = 8'haa;
  localparam logic [7:0]  KEY_SECOND = 8'h55;
  localparam logic [1:0]  PRE_LAST   = 2'h3;
  localparam logic [1:0]  SYNC_CYC   = 2'h3;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {KEY_IDLE = 2'b00, KEY_HALF = 2'b01} wwd_key_t;
  typedef struct packed {
    logic run;
    logic rst;
    logic prot;
    logic lock;
  } wwd_mode_t;
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } wwd_apb_req_t;
  typedef struct packed {
    wwd_mode_t   mode_s;
    wwd_mode_t   eff;
    logic [23:0] tc_s;
    logic [23:0] tc_e;
    logic [31:0] alert;
    logic [23:0] early;
    logic [1:0]  pend;
    logic        tof;
    logic        wflag;
    wwd_key_t    key;
    logic        running;
    logic [23:0] cnt;
    logic [1:0]  pre;
    logic        cclk_q;
    logic [23:0] cap;
    logic [23:0] view;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        rst_req;
  } wwd_state_t;
  localparam wwd_state_t ST_RST = '{tc_s: TC_RST, tc_e: TC_RST, alert: ALERT_RST, early: EARLY_RST,
                                    cnt: CNT_RST, cap: CNT_RST, view: CNT_RST, key: KEY_IDLE, default: '0};
endpackage
`default_nettype wire

/* verilog/wwd_top.sv */
/*
  Windowed supervisor: APB register slave, prescaler, down-counter, key sequence, window check.
  Assumes counter_clock_i is a slow level synchronous to clk_i; the chip reset request is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Counting clock level
  input  wire logic              counter_clock_i,
  // APB slave
  input  wire wwd_pkg::wwd_apb_req_t apb_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // System side
  output logic                   chip_reset_req_o,
  output logic                   warning_irq_o,
  output logic                   osc_lock_o
);
  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  wwd_pkg::wwd_state_t st_r;
  wwd_pkg::wwd_state_t st_nxt;
  wwd_pkg::wwd_state_t keep;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        cclk_rise;
  logic        key_wr;
  logic        key_first;
  logic        feed_ok;
  logic        feed_err;
  logic        early_feed;
  logic        cnt_tick;
  logic        expire;
  logic        tc_wr;
  logic        tc_open;
  logic        tc_block;
  logic        tout;
  logic [23:0] reload;
  logic [23:0] cnt_dec;

  assign acc       = apb_i.sel & ~apb_i.enable;
  assign wr        = acc & apb_i.write;
  assign rd        = acc & ~apb_i.write;
  assign cclk_rise = counter_clock_i & ~st_r.cclk_q;
  assign key_wr    = wr && (apb_i.addr == wwd_pkg::OFS_KEY);
  assign key_first = key_wr && (apb_i.wdata[7:0] == wwd_pkg::KEY_FIRST);
  assign feed_ok   = key_wr && (st_r.key == wwd_pkg::KEY_HALF) && (apb_i.wdata[7:0] == wwd_pkg::KEY_SECOND);
  assign feed_err  = key_wr && !key_first && !feed_ok && st_r.eff.run;
  assign early_feed = feed_ok && st_r.running && (st_r.cnt > st_r.early);
  assign cnt_tick  = cclk_rise && st_r.running && (st_r.pre == wwd_pkg::PRE_LAST) && (st_r.cnt != 24'h000000);
  assign cnt_dec   = st_r.cnt - 24'h000001;
  assign expire    = cnt_tick && (st_r.cnt == 24'h000001);
  assign tc_wr     = wr && (apb_i.addr == wwd_pkg::OFS_TC);
  assign tc_open   = !st_r.eff.prot || (({8'h00, st_r.cnt} < st_r.alert) && (st_r.cnt < st_r.early));
  assign tc_block  = tc_wr && !tc_open;
  assign tout      = expire || feed_err || early_feed || tc_block;
  assign reload    = (st_r.tc_e < wwd_pkg::TC_MIN) ? wwd_pkg::TC_MIN : st_r.tc_e;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt         = st_r;
    keep           = st_r;
    st_nxt.cclk_q  = counter_clock_i;
    st_nxt.ready   = acc;
    st_nxt.slverr  = 1'b0;
    st_nxt.rdata   = 32'h00000000;
    st_nxt.rst_req = 1'b0;
    // Bus clears come first so a same-cycle hardware set wins
    if (wr) begin
      case (apb_i.addr)
        wwd_pkg::OFS_SETUP: begin
          // Sticky bits: zero writes are ignored
          st_nxt.mode_s.run  = st_r.mode_s.run  | apb_i.wdata[wwd_pkg::BIT_RUN];
          st_nxt.mode_s.rst  = st_r.mode_s.rst  | apb_i.wdata[wwd_pkg::BIT_RST];
          st_nxt.mode_s.prot = st_r.mode_s.prot | apb_i.wdata[wwd_pkg::BIT_PROT];
          st_nxt.mode_s.lock = st_r.mode_s.lock | apb_i.wdata[wwd_pkg::BIT_LOCK];
          if (!apb_i.wdata[wwd_pkg::BIT_TOF]) begin
            st_nxt.tof = 1'b0;
          end
          if (apb_i.wdata[wwd_pkg::BIT_WRN]) begin
            st_nxt.wflag = 1'b0;
          end
          st_nxt.pend = wwd_pkg::SYNC_CYC;
        end
        wwd_pkg::OFS_TC: begin
          if (tc_open) begin
            st_nxt.tc_s = apb_i.wdata[23:0];
            st_nxt.pend = wwd_pkg::SYNC_CYC;
          end
        end
        wwd_pkg::OFS_ALERT: st_nxt.alert = apb_i.wdata;
        wwd_pkg::OFS_EARLY: st_nxt.early = apb_i.wdata[23:0];
        wwd_pkg::OFS_KEY:   st_nxt.slverr = 1'b0;
        wwd_pkg::OFS_VIEW:  st_nxt.slverr = 1'b0;
        default:            st_nxt.slverr = 1'b1;
      endcase
    end
    if (rd) begin
      case (apb_i.addr)
        wwd_pkg::OFS_SETUP: st_nxt.rdata = {26'h0000000, st_r.mode_s.lock, st_r.mode_s.prot,
                                            st_r.wflag, st_r.tof, st_r.mode_s.rst, st_r.mode_s.run};
        wwd_pkg::OFS_TC:    st_nxt.rdata = {8'h00, st_r.tc_s};
        wwd_pkg::OFS_VIEW:  st_nxt.rdata = {8'h00, st_r.view};
        wwd_pkg::OFS_ALERT: st_nxt.rdata = st_r.alert;
        wwd_pkg::OFS_EARLY: st_nxt.rdata = {8'h00, st_r.early};
        wwd_pkg::OFS_KEY:   st_nxt.rdata = 32'h00000000;
        default:            st_nxt.slverr = 1'b1;
      endcase
    end
    // Settings reach the counting logic only after three counter-clock edges
    if (cclk_rise && (st_r.pend != 2'h0)) begin
      st_nxt.pend = st_r.pend - 2'h1;
      if (st_r.pend == 2'h1 && !(wr && (apb_i.addr == wwd_pkg::OFS_SETUP || (tc_wr && tc_open)))) begin
        st_nxt.eff  = st_r.mode_s;
        st_nxt.tc_e = st_r.tc_s;
      end
    end
    if (wr && (apb_i.addr == wwd_pkg::OFS_SETUP || (tc_wr && tc_open))) begin
      st_nxt.pend = wwd_pkg::SYNC_CYC;
    end
    // Readback: lock on the counter clock, then hand across to the bus view
    if (cclk_rise) begin
      st_nxt.cap = st_r.cnt;
      if (st_r.running) begin
        st_nxt.pre = st_r.pre + 2'h1;
      end
    end
    st_nxt.view = st_r.cap;
    if (cnt_tick) begin
      st_nxt.cnt = cnt_dec;
      if ({8'h00, cnt_dec} == st_r.alert) begin
        st_nxt.wflag = 1'b1;
      end
    end
    // Key sequence
    if (key_wr) begin
      st_nxt.key = key_first ? wwd_pkg::KEY_HALF : wwd_pkg::KEY_IDLE;
    end
    if (feed_ok && st_r.eff.run) begin
      st_nxt.running = 1'b1;
      st_nxt.cnt     = reload;
      st_nxt.pre     = 2'h0;
    end
    if (tout) begin
      st_nxt.tof = 1'b1;
    end
    // Self reset: everything back to reset values except the flag, the reset request, the counter clock sample and the bus answer
    if (tout && st_r.eff.rst) begin
      keep           = st_nxt;
      st_nxt         = wwd_pkg::ST_RST;
      st_nxt.tof     = 1'b1;
      st_nxt.rst_req = 1'b1;
      st_nxt.cclk_q  = keep.cclk_q;
      st_nxt.ready   = keep.ready;
      st_nxt.rdata   = keep.rdata;
      st_nxt.slverr  = keep.slverr;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= wwd_pkg::ST_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o         = st_r.rdata;
  assign pready_o         = st_r.ready;
  assign pslverr_o        = st_r.slverr;
  assign chip_reset_req_o = st_r.rst_req;
  assign warning_irq_o    = st_r.wflag;
  assign osc_lock_o       = st_r.eff.lock;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_decrement;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      cnt_tick && !feed_ok && !(tout && st_r.eff.rst) |=> st_r.cnt == $past(st_r.cnt) - 24'h000001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not step down by one");

  property p_min_load;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      feed_ok && st_r.eff.run && !(tout && st_r.eff.rst) |=> st_r.cnt >= 24'h0000ff && st_r.running;
  endproperty
  a_min_load: assert property (p_min_load) else $error("reload below minimum");

  property p_start_on_feed;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      $rose(st_r.running) |-> $past(feed_ok) && $past(st_r.eff.run);
  endproperty
  a_start_on_feed: assert property (p_start_on_feed) else $error("counter started without a feed");

  property p_expire_reset;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      expire && st_r.eff.rst |=> st_r.rst_req && st_r.tof ##1 !st_r.rst_req;
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("expiry gave no reset pulse");

  property p_early;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      early_feed |=> st_r.tof;
  endproperty
  a_early: assert property (p_early) else $error("early reload not flagged");

  property p_flag_kept;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.rst_req |-> st_r.tof && !st_r.running;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag lost over self reset");

  property p_warn;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      cnt_tick && ({8'h00, cnt_dec} == st_r.alert) && !(tout && st_r.eff.rst) |=> st_r.wflag;
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag missed");

  property p_key_err;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      feed_err |=> st_r.tof;
  endproperty
  a_key_err: assert property (p_key_err) else $error("bad key not flagged");

  property p_no_disable;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.eff.run |=> st_r.eff.run || st_r.rst_req;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("timer disabled by software");

  property p_protect;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      tc_block && !st_r.eff.rst |=> st_r.tof && st_r.tc_s == $past(st_r.tc_s);
  endproperty
  a_protect: assert property (p_protect) else $error("protected constant changed");

  property p_sync;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      $changed(st_r.eff) |-> st_r.rst_req || ($past(cclk_rise) && $past(st_r.pend) == 2'h1);
  endproperty
  a_sync: assert property (p_sync) else $error("setting applied off schedule");

  property p_prescale;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      cclk_rise && st_r.running && !feed_ok && !(tout && st_r.eff.rst) |=> st_r.pre == $past(st_r.pre) + 2'h1;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler skipped a counter clock");

  property p_load_floor;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      feed_ok && st_r.eff.run && !(tout && st_r.eff.rst) |=>
        st_r.cnt == (($past(st_r.tc_e) < wwd_pkg::TC_MIN) ? wwd_pkg::TC_MIN : $past(st_r.tc_e));
  endproperty
  a_load_floor: assert property (p_load_floor) else $error("reload value wrong");

  property p_idle_hold;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      !st_r.running && !feed_ok && !(tout && st_r.eff.rst) |=> st_r.cnt == $past(st_r.cnt);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved before first feed");

  property p_expire_flag;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      expire |=> st_r.tof;
  endproperty
  a_expire_flag: assert property (p_expire_flag) else $error("expiry not flagged");

  property p_hold_zero;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.running && st_r.cnt == 24'h000000 && !feed_ok && !(tout && st_r.eff.rst) |=> st_r.cnt == 24'h000000;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter left zero without a feed");

  property p_event_reset;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      tout && st_r.eff.rst |=> st_r.rst_req && st_r.tof && !st_r.running;
  endproperty
  a_event_reset: assert property (p_event_reset) else $error("timeout event gave no reset");

  property p_warn_kept;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.wflag && !(wr && apb_i.addr == wwd_pkg::OFS_SETUP && apb_i.wdata[wwd_pkg::BIT_WRN]) &&
        !(tout && st_r.eff.rst) |=> st_r.wflag;
  endproperty
  a_warn_kept: assert property (p_warn_kept) else $error("warning flag dropped without a clear");

  property p_rst_sticky;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.mode_s.rst |=> st_r.mode_s.rst || st_r.rst_req;
  endproperty
  a_rst_sticky: assert property (p_rst_sticky) else $error("reset bit cleared by software");

  property p_prot_sticky;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      st_r.mode_s.prot |=> st_r.mode_s.prot || st_r.rst_req;
  endproperty
  a_prot_sticky: assert property (p_prot_sticky) else $error("protect bit cleared by software");
endmodule
`default_nettype wire

/* verilog/wwd_dummy_guard.sv */
`default_nettype none
`default_nettype wire

/* bench/wwd_apb_bfm.sv */
/*
  APB master model standing in for the processor software.
  Assumes a zero-wait slave that answers in the access phase.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_apb_bfm (
  // Bus answer
  input  wire logic                  clk_i,
  input  wire logic [31:0]           prdata_i,
  input  wire logic                  pready_i,
  input  wire logic                  pslverr_i,
  // Bus request
  output var wwd_pkg::wwd_apb_req_t  apb_o
);
  initial apb_o = '0;
  // Drives on falling edges; request held through the edge that samples ready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(negedge clk_i);
    apb_o = '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
    @(negedge clk_i);
    apb_o.enable = 1'b1;
    while (pready_i !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    q = prdata_i;
    // A missing ready reads as an error
    e = pslverr_i | (pready_i !== 1'b1);
    @(posedge clk_i);
    @(negedge clk_i);
    apb_o = '0;
  endtask
endmodule
`default_nettype wire

/* bench/tb_windowed_wdog_timer.sv */
/*
  Self-checking bench for the windowed supervisor.
  Assumes the BFM model and a free-running counting clock of four system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_wdog_timer;
  logic                  clk_i, rst_i, ce, cclk, pready, pslverr, rreq, wirq, lock, e;
  logic [31:0]           prdata, q, v;
  wwd_pkg::wwd_apb_req_t apb;
  int                    miscompares = 0, compares = 0, resets = 0;
  wwd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .counter_clock_i(cclk), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .chip_reset_req_o(rreq),
    .warning_irq_o(wirq), .osc_lock_o(lock));
  wwd_apb_bfm BFM (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr), .apb_o(apb));
  // ----------------------------------------
  // Clocks and helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    cclk = 1'b0;
    forever begin
      repeat (2) @(negedge clk_i);
      cclk = ~cclk;
    end
  end
  always @(posedge clk_i) if (rreq === 1'b1) resets <= resets + 1;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    BFM.xfer(1'b1, a, d, q, e);
    chk("wr_err", 32'h0, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    BFM.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, ex, q);
  endtask
  task automatic feed;
    wr(wwd_pkg::OFS_KEY, 32'haa);
    wr(wwd_pkg::OFS_KEY, 32'h55);
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    ce    = 1'b1;
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    rd(wwd_pkg::OFS_SETUP, 32'h0, "setup_rst");
    rd(wwd_pkg::OFS_TC, 32'hff, "tc_rst");
    rd(wwd_pkg::OFS_VIEW, 32'hff, "view_rst");
    rd(wwd_pkg::OFS_ALERT, 32'h0, "alert_rst");
    rd(wwd_pkg::OFS_EARLY, 32'hffffff, "early_rst");
    rd(12'h010, 32'h0, "hole_rd");
    chk("hole_err", 32'h1, {31'h0, e});
    wr(wwd_pkg::OFS_TC, 32'h10);
    wr(wwd_pkg::OFS_SETUP, 32'h21);
    repeat (64) @(negedge clk_i);
    chk("lock", 32'h1, {31'h0, lock});
    rd(wwd_pkg::OFS_VIEW, 32'hff, "view_idle");
    feed();
    repeat (64) @(negedge clk_i);
    BFM.xfer(1'b0, wwd_pkg::OFS_VIEW, 32'h0, q, e);
    chk("view_err", 32'h0, {31'h0, e});
    chk("view_step", 32'h1, {31'h0, (q >= 32'hfa && q <= 32'hfc)});
    // Clock enable low: the count may move by at most one
    v  = q;
    ce = 1'b0;
    repeat (200) @(negedge clk_i);
    ce = 1'b1;
    BFM.xfer(1'b0, wwd_pkg::OFS_VIEW, 32'h0, q, e);
    chk("freeze", 32'h1, {31'h0, (v - q <= 32'h1)});
    wr(wwd_pkg::OFS_SETUP, 32'h20);
    rd(wwd_pkg::OFS_SETUP, 32'h21, "run_sticky");
    wr(wwd_pkg::OFS_ALERT, 32'hf0);
    for (int i = 0; i < 400 && wirq !== 1'b1; i++) @(negedge clk_i);
    chk("warn_set", 32'h1, {31'h0, wirq});
    wr(wwd_pkg::OFS_SETUP, 32'h29);
    chk("warn_clr", 32'h0, {31'h0, wirq});
    wr(wwd_pkg::OFS_EARLY, 32'h80);
    feed();
    rd(wwd_pkg::OFS_SETUP, 32'h25, "early_feed");
    wr(wwd_pkg::OFS_SETUP, 32'h21);
    rd(wwd_pkg::OFS_SETUP, 32'h21, "tof_clr");
    wr(wwd_pkg::OFS_KEY, 32'h12);
    rd(wwd_pkg::OFS_SETUP, 32'h25, "key_err");
    wr(wwd_pkg::OFS_SETUP, 32'h23);
    repeat (16) @(negedge clk_i);
    wr(wwd_pkg::OFS_KEY, 32'h12);
    chk("chip_rst", 32'h1, resets);
    rd(wwd_pkg::OFS_SETUP, 32'h04, "tof_kept");
    rd(wwd_pkg::OFS_TC, 32'hff, "tc_self_rst");
    wr(wwd_pkg::OFS_SETUP, 32'h01);
    repeat (16) @(negedge clk_i);
    feed();
    rd(wwd_pkg::OFS_SETUP, 32'h01, "run_again");
    repeat (16) @(negedge clk_i);
    wr(wwd_pkg::OFS_SETUP, 32'h11);
    repeat (16) @(negedge clk_i);
    wr(wwd_pkg::OFS_TC, 32'h40);
    rd(wwd_pkg::OFS_TC, 32'hff, "tc_locked");
    rd(wwd_pkg::OFS_SETUP, 32'h15, "prot_tof");
    wr(wwd_pkg::OFS_SETUP, 32'h10);
    repeat (4200) @(negedge clk_i);
    rd(wwd_pkg::OFS_SETUP, 32'h1d, "expiry");
    rd(wwd_pkg::OFS_VIEW, 32'h0, "view_zero");
    chk("no_rst", 32'h1, resets);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
